// *** hw/wake_cfg_device.sv ***
// Purpose: Selective wake configuration registers behind a 16-bit link.
// Assumes: Link frames are mode 0, MSB first; response is one frame late.
// Notes:   Link logic runs on the serial clock, registers on CLK.
`timescale 1ns/100ps

// Contract
// - Calibration enable bit 7 drives calibration mode
// - Recalibration unlocked only by trim pattern 11
// - Receiver option writes ignored unless unlocked
// - Oscillator syncs to transmit pin during calibration
// - Timeout interrupt only when mask bit 4 set
// - Wake enabled only while valid bit reads 1
// - Valid clears on wake, reset, data change
// - Stop-mode config write forces valid to 0
// - Timeout flag updates only with wake mode
// - Reserved bits read 0, writes ignored
// - Quanta register 8 bits, resets to a0
// - Sample point 6 bits, resets to 33
// - Identifier split over four byte registers
// - Standard identifier sits in bits 28 to 18
// - Controller never programs remote request 1
// - Extension bit selects 11 or 29 bits
// - Mask bit 1 compares, 0 ignores
// - Identifier and mask clear on resets only
// - Length code compared bit for bit
module wake_cfg_device
  import wake_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  spi_link_if.device LINK,
  input wire logic SOFT_RST,
  input wire logic STOP_MODE,
  input wire logic CAN_WAKE_SEL,
  input wire logic CAN_TIMEOUT_EVT,
  input wire logic WAKE_EVENT,
  input wire logic RX_VALID,
  input wire logic [28:0] RX_IDENT,
  input wire logic RX_IDE,
  input wire logic RX_RTR,
  input wire logic [3:0] RX_LEN,
  output logic IRQ,
  output logic WAKE_DETECT,
  output logic CFG_VALID,
  output logic CAN_TIMEOUT_FLAG,
  output logic CALIB_ACTIVE,
  output logic TRIM_UNLOCKED,
  output logic OSC_SYNC_PULSE,
  output logic [7:0] QUANTA_PER_BIT,
  output logic [5:0] SAMPLE_POINT,
  output logic [7:0] LP_RX_OPTION
);

  // ==========================================================
  // Link domain: shift in on rising edge, out on falling edge
  logic [4:0] cnt_ff;
  logic [14:0] shr_ff;
  logic [15:0] frame_ff;
  logic frame_tgl_ff;
  logic miso_ff;
  logic [15:0] resp_ff;
  wire link_rst_n = RST_N & ~LINK.csn_n;
  wire [3:0] out_idx = FRM_LAST_BIT - cnt_ff[3:0];
  wire last_bit = (cnt_ff[3:0] == FRM_LAST_BIT) && !cnt_ff[4];

  // Bit counter and input shifter, cleared while deselected
  always_ff @(posedge LINK.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_ff <= 5'h00;
      shr_ff <= 15'h0000;
    end else if (!cnt_ff[4]) begin
      cnt_ff <= cnt_ff + 5'h01;
      shr_ff <= {shr_ff[13:0], LINK.mosi};
    end
  end

  // Whole frame is held and announced by a toggle
  always_ff @(posedge LINK.sck or negedge RST_N) begin
    if (!RST_N) begin
      frame_ff <= 16'h0000;
      frame_tgl_ff <= 1'b0;
    end else if (last_bit) begin
      frame_ff <= {shr_ff, LINK.mosi};
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end

  // Response bit for the next rising edge; first bit is always 0
  always_ff @(negedge LINK.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_ff <= 1'b0;
    end else begin
      miso_ff <= resp_ff[out_idx];
    end
  end

  assign LINK.miso = miso_ff;

  // ==========================================================
  // Crossing into the register clock
  logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
  logic txd_s1_ff, txd_s2_ff, txd_s3_ff;
  logic evt_d_ff;

  // Two-flop synchronisers plus one stage for edge detection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      txd_s1_ff <= 1'b1; // Pin idles high: no false edge
      txd_s2_ff <= 1'b1;
      txd_s3_ff <= 1'b1;
    end else begin
      tgl_s1_ff <= frame_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      txd_s1_ff <= LINK.txd;
      txd_s2_ff <= txd_s1_ff;
      txd_s3_ff <= txd_s2_ff;
    end
  end

  // ==========================================================
  // Frame decode
  logic [7:0] ctrl_ff, quanta_ff, sample_ff, id3_ff, id2_ff, id1_ff;
  logic [7:0] id0_ff, mask3_ff, len_ff, rxopt_ff;
  logic valid_ff, timeout_ff;
  logic [7:0] sel_val;

  wire frame_evt = tgl_s2_ff ^ tgl_s3_ff;
  wire [6:0] f_addr = frame_ff[14:8];
  wire [7:0] f_data = frame_ff[7:0];
  wire wr_evt = frame_evt && frame_ff[FRM_WRITE];
  wire rd_ctrl = frame_evt && !frame_ff[FRM_WRITE] && (f_addr == ADDR_CTRL);
  wire unlocked = (ctrl_ff[CTRL_TRIM_HI:CTRL_TRIM_LO] == TRIM_UNLOCK);
  wire wr_ok = (f_addr != ADDR_RX_OPT) || unlocked;
  wire reg_wr = wr_evt && wr_ok;
  wire [7:0] wval = f_data & wr_mask(f_addr);
  wire wr_ctrl = wr_evt && (f_addr == ADDR_CTRL);

  // Current value of the addressed register, reserved bits as 0
  always_comb begin
    unique case (f_addr)
      ADDR_CTRL: sel_val = {ctrl_ff[7:4], 3'h0, valid_ff};
      ADDR_QUANTA: sel_val = quanta_ff;
      ADDR_SAMPLE: sel_val = sample_ff;
      ADDR_ID3: sel_val = id3_ff;
      ADDR_ID2: sel_val = id2_ff;
      ADDR_ID1: sel_val = id1_ff;
      ADDR_ID0: sel_val = id0_ff;
      ADDR_MASK3: sel_val = mask3_ff;
      ADDR_LEN_CODE: sel_val = len_ff;
      ADDR_RX_OPT: sel_val = rxopt_ff;
      default: sel_val = 8'h00;
    endcase
  end

  // ==========================================================
  // Configuration registers (soft reset restores their defaults)
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= RST_ZERO;
      quanta_ff <= RST_QUANTA;
      sample_ff <= RST_SAMPLE;
      id3_ff <= RST_ZERO;
      id2_ff <= RST_ZERO;
      id1_ff <= RST_ZERO;
      id0_ff <= RST_ZERO;
      mask3_ff <= RST_ZERO;
      len_ff <= RST_ZERO;
      rxopt_ff <= RST_ZERO;
    end else if (SOFT_RST) begin
      ctrl_ff <= RST_ZERO;
      quanta_ff <= RST_QUANTA;
      sample_ff <= RST_SAMPLE;
      id3_ff <= RST_ZERO;
      id2_ff <= RST_ZERO;
      id1_ff <= RST_ZERO;
      id0_ff <= RST_ZERO;
      mask3_ff <= RST_ZERO;
      len_ff <= RST_ZERO;
      rxopt_ff <= RST_ZERO;
    end else if (reg_wr) begin
      unique case (f_addr)
        ADDR_CTRL: ctrl_ff <= wval;
        ADDR_QUANTA: quanta_ff <= wval;
        ADDR_SAMPLE: sample_ff <= wval;
        ADDR_ID3: id3_ff <= wval;
        ADDR_ID2: id2_ff <= wval;
        ADDR_ID1: id1_ff <= wval;
        ADDR_ID0: id0_ff <= wval;
        ADDR_MASK3: mask3_ff <= wval;
        ADDR_LEN_CODE: len_ff <= wval;
        ADDR_RX_OPT: rxopt_ff <= wval;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Wake frame match
  wire [28:0] prog_ident = {id3_ff, id2_ff, id1_ff, id0_ff[6:2]};
  wire [28:0] full_sel = {mask3_ff, LOW_IDENT_SEL};
  wire [28:0] cmp_sel = id0_ff[ID0_IDE] ? full_sel
                        : (full_sel & STD_IDENT_SEL);
  wire ident_eq = ((RX_IDENT ^ prog_ident) & cmp_sel) == 29'h0000_0000;
  wire flags_eq = (RX_IDE == id0_ff[ID0_IDE]) && (RX_RTR == id0_ff[ID0_RTR]);
  wire len_eq = (RX_LEN == len_ff[3:0]);
  wire wake_on = valid_ff && CAN_WAKE_SEL;
  wire wake_hit = RX_VALID && wake_on && ident_eq && flags_eq
                  && len_eq;

  // ==========================================================
  // Valid bit: stop-mode writes clear first, then software set
  wire stop_clr = wr_evt && STOP_MODE
                  && (is_cfg_addr(f_addr) || wr_ctrl);
  wire data_chg = reg_wr && is_cfg_addr(f_addr)
                  && (wval != sel_val);
  wire sw_set = wr_ctrl && f_data[CTRL_VALID];
  wire sw_clr = wr_ctrl && !f_data[CTRL_VALID];
  wire auto_clr = wake_hit || WAKE_EVENT || data_chg;
  wire nxt_valid = (SOFT_RST || stop_clr) ? 1'b0
                   : sw_set ? 1'b1
                   : (auto_clr || sw_clr) ? 1'b0 : valid_ff;

  // Timeout flag: set wins over the clear by a control read
  wire to_set = CAN_TIMEOUT_EVT && CAN_WAKE_SEL;
  wire nxt_timeout = SOFT_RST ? 1'b0
                     : to_set ? 1'b1
                     : rd_ctrl ? 1'b0 : timeout_ff;
  wire cal_on = ctrl_ff[CTRL_CAL_EN] && unlocked;
  wire txd_edge = txd_s2_ff ^ txd_s3_ff;

  // Status, strobes and outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      valid_ff <= 1'b0;
      timeout_ff <= 1'b0;
      evt_d_ff <= 1'b0;
      resp_ff <= 16'h0000;
      IRQ <= 1'b0;
      WAKE_DETECT <= 1'b0;
      OSC_SYNC_PULSE <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      timeout_ff <= nxt_timeout;
      evt_d_ff <= frame_evt;
      if (evt_d_ff) begin
        resp_ff <= {1'b0, valid_ff, timeout_ff, 5'h00, sel_val};
      end
      IRQ <= timeout_ff && ctrl_ff[CTRL_TO_IRQ];
      WAKE_DETECT <= wake_hit;
      OSC_SYNC_PULSE <= cal_on && txd_edge;
    end
  end

  // Register-backed outputs
  assign CFG_VALID = valid_ff;
  assign CAN_TIMEOUT_FLAG = timeout_ff;
  assign CALIB_ACTIVE = ctrl_ff[CTRL_CAL_EN];
  assign QUANTA_PER_BIT = quanta_ff;
  assign SAMPLE_POINT = sample_ff[5:0];
  assign LP_RX_OPTION = rxopt_ff;

  // Unlock state kept in its own flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRIM_UNLOCKED <= 1'b0;
    end else begin
      TRIM_UNLOCKED <= unlocked;
    end
  end

endmodule

// *** hw/wake_cfg_pkg.sv ***
// Purpose: Shared constants and types for the selective wake config link.
// Assumes: 16-bit frames, bit 15 write flag, 14:8 address, 7:0 data.
// Notes:   Both ends and the bench use this package.
package wake_cfg_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [6:0] ADDR_CTRL = 7'h20;
  localparam logic [6:0] ADDR_QUANTA = 7'h21;
  localparam logic [6:0] ADDR_SAMPLE = 7'h22;
  localparam logic [6:0] ADDR_ID3 = 7'h23;
  localparam logic [6:0] ADDR_ID2 = 7'h24;
  localparam logic [6:0] ADDR_ID1 = 7'h25;
  localparam logic [6:0] ADDR_ID0 = 7'h26;
  localparam logic [6:0] ADDR_MASK3 = 7'h27;
  localparam logic [6:0] ADDR_LEN_CODE = 7'h2b;
  localparam logic [6:0] ADDR_RX_OPT = 7'h3f;

  // ==========================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_QUANTA = 8'ha0;
  localparam logic [7:0] RST_SAMPLE = 8'h33;
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_CTRL = 8'hf0;
  localparam logic [7:0] WMASK_SAMPLE = 8'h3f;
  localparam logic [7:0] WMASK_ID0 = 8'h7f;
  localparam logic [7:0] WMASK_LEN = 8'h0f;

  // ==========================================================
  // Field positions
  localparam int CTRL_CAL_EN = 7;
  localparam int CTRL_TRIM_HI = 6;
  localparam int CTRL_TRIM_LO = 5;
  localparam int CTRL_TO_IRQ = 4;
  localparam int CTRL_VALID = 0;
  localparam int ID0_RTR = 1;
  localparam int ID0_IDE = 0;
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;
  localparam int FRM_WRITE = 15;
  localparam logic [3:0] FRM_LAST_BIT = 4'hf;
  localparam logic [28:0] STD_IDENT_SEL = 29'h1ffc_0000;
  localparam logic [20:0] LOW_IDENT_SEL = 21'h1f_ffff;

  // ==========================================================
  // Host timing in host clock cycles
  localparam logic [2:0] SCK_HALF = 3'h4;
  localparam logic [2:0] SCK_LAST_PH = 3'h7;
  localparam logic [3:0] GAP_CYCLES = 4'h8;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_SHIFT = 4'b0100,
    H_GAP = 4'b1000
  } host_state_t;

  // Configuration data registers other than the control register
  function automatic logic is_cfg_addr(input logic [6:0] a);
    return ((a >= ADDR_QUANTA) && (a <= ADDR_MASK3)) ||
           (a == ADDR_LEN_CODE) || (a == ADDR_RX_OPT);
  endfunction

  // Bits that a write may change at a given address
  function automatic logic [7:0] wr_mask(input logic [6:0] a);
    if (a == ADDR_CTRL) return WMASK_CTRL;
    if (a == ADDR_SAMPLE) return WMASK_SAMPLE;
    if (a == ADDR_ID0) return WMASK_ID0;
    if (a == ADDR_LEN_CODE) return WMASK_LEN;
    return WMASK_FULL;
  endfunction

endpackage

// *** hw/spi_link_if.sv ***
// Purpose: Serial link between controller and wake configuration block.
// Assumes: Host makes the serial clock; all wires are push-pull.
// Notes:   No clocking block; the bench joins the two ends here.
`timescale 1ns/100ps
interface spi_link_if;
  logic csn_n;
  logic sck;
  logic mosi;
  logic miso;
  logic txd;

  modport device (input csn_n, input sck, input mosi, input txd,
                  output miso);
  modport host (output csn_n, output sck, output mosi, output txd,
                input miso);
endinterface

// *** hw/wake_cfg_host.sv ***
// Purpose: Controller end: turns byte commands into 16-bit link frames.
// Assumes: Serial clock is CLK divided by eight; frames spaced by a gap.
// Notes:   Response of each frame belongs to the previous command.
`timescale 1ns/100ps
module wake_cfg_host
  import wake_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  spi_link_if.host LINK,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [6:0] CMD_ADDR,
  input wire logic [7:0] CMD_DATA,
  input wire logic TXD_LEVEL,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic [15:0] RESP_WORD
);

  // ==========================================================
  // Frame sequencer
  host_state_t state_ff;
  logic [2:0] ph_ff;
  logic [3:0] bit_ff;
  logic [3:0] gap_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic csn_ff, sck_ff, mosi_ff, txd_ff;
  logic miso_s1_ff, miso_s2_ff;

  // Remote request forced to 0 on identifier writes
  wire id0_wr = CMD_WRITE && (CMD_ADDR == ADDR_ID0);
  wire [7:0] safe_data = id0_wr ? (CMD_DATA & ~(8'h01 << ID0_RTR))
                         : CMD_DATA;
  // Bytes go out verbatim apart from that bit, so the ident layout is software's
  wire [15:0] tx_word = {CMD_WRITE, CMD_ADDR, safe_data};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= H_IDLE;
      ph_ff <= 3'h0;
      bit_ff <= 4'h0;
      gap_ff <= 4'h0;
      tx_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      csn_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      CMD_READY <= 1'b1;
      RESP_VALID <= 1'b0;
      RESP_WORD <= 16'h0000;
    end else begin
      RESP_VALID <= 1'b0;
      unique case (state_ff)
        H_IDLE: begin
          if (CMD_VALID) begin
            tx_ff <= tx_word;
            mosi_ff <= tx_word[15];
            csn_ff <= 1'b0;
            CMD_READY <= 1'b0;
            ph_ff <= 3'h0;
            state_ff <= H_LEAD;
          end
        end
        H_LEAD: begin
          ph_ff <= ph_ff + 3'h1;
          if (ph_ff == SCK_HALF - 3'h1) begin
            ph_ff <= 3'h0;
            bit_ff <= 4'h0;
            state_ff <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          ph_ff <= ph_ff + 3'h1;
          if (ph_ff == SCK_HALF - 3'h1) begin
            sck_ff <= 1'b1;
            rx_ff <= {rx_ff[14:0], miso_s2_ff};
          end
          if (ph_ff == SCK_LAST_PH) begin
            sck_ff <= 1'b0;
            bit_ff <= bit_ff + 4'h1;
            tx_ff <= {tx_ff[14:0], 1'b0};
            mosi_ff <= tx_ff[14];
            if (bit_ff == FRM_LAST_BIT) begin
              csn_ff <= 1'b1;
              mosi_ff <= 1'b0;
              gap_ff <= 4'h0;
              RESP_VALID <= 1'b1;
              RESP_WORD <= rx_ff;
              state_ff <= H_GAP;
            end
          end
        end
        H_GAP: begin
          gap_ff <= gap_ff + 4'h1;
          if (gap_ff == GAP_CYCLES - 4'h1) begin
            CMD_READY <= 1'b1;
            state_ff <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Response pin synchroniser and calibration pin driver
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else begin
      miso_s1_ff <= LINK.miso;
      miso_s2_ff <= miso_s1_ff;
      txd_ff <= TXD_LEVEL;
    end
  end

  assign LINK.csn_n = csn_ff;
  assign LINK.sck = sck_ff;
  assign LINK.mosi = mosi_ff;
  assign LINK.txd = txd_ff;

endmodule

// *** verification/wake_link_asserts.sv ***
// Purpose: Wire checks on the serial link between host and device.
// Assumes: Host makes sck as CLK/8; each frame carries 16 bits.
// Notes:   Sampled on the host clock; helper counters track frames.
`timescale 1ns/100ps
module wake_link_asserts (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic csn_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic txd
);
  // ==========================================================
  // Frame shape counters
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  logic [4:0] rise_ff;
  logic [4:0] nxt_rise;
  logic sck_ff;
  logic len_ok;

  // Count selected cycles and rising sck edges, clear while idle
  assign nxt_low = csn_n ? 8'h00 : low_ff + 8'h01;
  assign nxt_rise = csn_n ? 5'h00 : rise_ff + {4'h0, sck & ~sck_ff};
  assign len_ok = (low_ff >= 8'h82) && (low_ff <= 8'h86);

  // Helper registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_ff <= 8'h00;
      rise_ff <= 5'h00;
      sck_ff <= 1'b0;
    end else begin
      low_ff <= nxt_low;
      rise_ff <= nxt_rise;
      sck_ff <= sck;
    end
  end

  // ==========================================================
  // Link properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sck_idle_a: assert property (csn_n |-> !sck)
    else $error("sck moved outside a frame");
  frame_length_a: assert property ($rose(csn_n) |-> len_ok)
    else $error("frame length off");
  bit_count_a: assert property ($rose(csn_n) |-> rise_ff == 5'h10)
    else $error("frame did not carry 16 clocks");
  sck_rate_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase not four cycles");
  frame_gap_a: assert property ($rose(csn_n) |-> csn_n [*8])
    else $error("gap between frames too short");
  lead_time_a: assert property ($fell(csn_n) |-> !sck [*4])
    else $error("sck rose too soon after select");
  mosi_hold_a: assert property (sck |-> $stable(mosi))
    else $error("mosi changed while sck high");
  miso_hold_a: assert property (sck |-> $stable(miso))
    else $error("miso changed while sck high");
  miso_idle_a: assert property (csn_n |-> !miso)
    else $error("miso not cleared while idle");
endmodule

// *** verification/tb_can_selective_wake_config.sv ***
// Purpose: Self-checking bench joining host and device over the link.
// Assumes: One command per frame; response trails by one frame.
// Notes:   Inputs change 1 ns after the rising clock edge.
`timescale 1ns/100ps
module tb_can_selective_wake_config;
  import wake_cfg_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] rst;
    logic [7:0] wr;
    logic [7:0] exp;
  } row_t;
  typedef struct packed {
    logic [28:0] flip;
    logic ide;
    logic rtr;
    logic [3:0] len;
    logic hit;
  } rx_t;
  logic CLK = 1'b0;
  logic RST_N;
  logic soft_rst = 1'b0, stop_mode = 1'b0, wake_sel = 1'b0;
  logic to_evt = 1'b0, wake_evt = 1'b0, rx_valid = 1'b0;
  logic [28:0] rx_ident = 29'h0;
  logic rx_ide = 1'b0, rx_rtr = 1'b0, txd_level = 1'b1;
  logic [3:0] rx_len = 4'h0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_data = 8'h00;
  logic irq, wake_det, cfg_valid, to_flag, calib, trim_unl, osc_sync;
  logic cmd_ready, resp_valid;
  logic [7:0] quanta, lp_opt;
  logic [5:0] sample;
  logic [15:0] resp_word, resp_last;
  int err_count = 0;
  int check_count = 0;
  int k;
  row_t rows [10] = '{
    '{ADDR_QUANTA, 8'ha0, 8'hff, 8'hff}, '{ADDR_SAMPLE, 8'h33, 8'hff, 8'h3f},
    '{ADDR_ID3, 8'h00, 8'ha5, 8'ha5}, '{ADDR_ID2, 8'h00, 8'h5a, 8'h5a},
    '{ADDR_ID1, 8'h00, 8'hc3, 8'hc3}, '{ADDR_ID0, 8'h00, 8'hff, 8'h7d},
    '{ADDR_MASK3, 8'h00, 8'h0f, 8'h0f}, '{ADDR_LEN_CODE, 8'h00, 8'hff, 8'h0f},
    '{ADDR_RX_OPT, 8'h00, 8'h55, 8'h00}, '{7'h7f, 8'h00, 8'h12, 8'h00}};
  rx_t cases [7] = '{
    '{29'h0, 1'b1, 1'b0, 4'hf, 1'b1}, '{29'h1000_0000, 1'b1, 1'b0, 4'hf, 1'b1},
    '{29'h0020_0000, 1'b1, 1'b0, 4'hf, 1'b0},
    '{29'h0000_0001, 1'b1, 1'b0, 4'hf, 1'b0},
    '{29'h0, 1'b0, 1'b0, 4'hf, 1'b0}, '{29'h0, 1'b1, 1'b1, 4'hf, 1'b0},
    '{29'h0, 1'b1, 1'b0, 4'he, 1'b0}};

  // ==========================================================
  // Design ends, link and checker
  spi_link_if spi_link_if_inst ();
  wake_cfg_host wake_cfg_host_inst (.CLK(CLK), .RST_N(RST_N),
    .LINK(spi_link_if_inst.host), .CMD_VALID(cmd_valid),
    .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
    .TXD_LEVEL(txd_level), .CMD_READY(cmd_ready),
    .RESP_VALID(resp_valid), .RESP_WORD(resp_word));
  wake_cfg_device wake_cfg_device_inst (.CLK(CLK), .RST_N(RST_N),
    .LINK(spi_link_if_inst.device), .SOFT_RST(soft_rst),
    .STOP_MODE(stop_mode), .CAN_WAKE_SEL(wake_sel),
    .CAN_TIMEOUT_EVT(to_evt), .WAKE_EVENT(wake_evt), .RX_VALID(rx_valid),
    .RX_IDENT(rx_ident), .RX_IDE(rx_ide), .RX_RTR(rx_rtr), .RX_LEN(rx_len),
    .IRQ(irq), .WAKE_DETECT(wake_det), .CFG_VALID(cfg_valid),
    .CAN_TIMEOUT_FLAG(to_flag), .CALIB_ACTIVE(calib),
    .TRIM_UNLOCKED(trim_unl), .OSC_SYNC_PULSE(osc_sync),
    .QUANTA_PER_BIT(quanta), .SAMPLE_POINT(sample), .LP_RX_OPTION(lp_opt));
  wake_link_asserts wake_link_asserts_inst (.CLK(CLK), .RST_N(RST_N),
    .csn_n(spi_link_if_inst.csn_n), .sck(spi_link_if_inst.sck),
    .mosi(spi_link_if_inst.mosi), .miso(spi_link_if_inst.miso),
    .txd(spi_link_if_inst.txd));

  // Clock
  always #5 CLK = ~CLK;

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic hang(input string nm);
    err_count++;
    $display("[FAIL] %s expected 1 seen 0", nm);
    complete_run();
  endtask

  // One command frame; ends once the host is ready again
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
    for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) step(1);
    if (k == 300) hang("ready");
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    step(1);
    cmd_valid = 1'b0;
    for (k = 0; k < 300 && resp_valid !== 1'b1; k++) step(1);
    if (k == 300) hang("response");
    resp_last = resp_word;
    step(1);
    for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) step(1);
    if (k == 300) hang("ready");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    #1 RST_N = 1'b0; // X to 0 gives every reset input an edge
    step(3);
    RST_N = 1'b1;
    chk("quanta", 8'ha0, quanta);
    chk("sample", 8'h33, {2'b00, sample});
    foreach (rows[i]) begin
      cmd(1'b0, rows[i].addr, 8'h00);
      cmd(1'b1, rows[i].addr, rows[i].wr);
      chk("reset value", rows[i].rst, resp_last[7:0]);
      cmd(1'b0, 7'h7f, 8'h00);
      chk("readback", rows[i].exp, resp_last[7:0]);
    end
    chk("quanta", 8'hff, quanta);
    cmd(1'b1, ADDR_ID0, 8'h7f);
    cmd(1'b0, 7'h7f, 8'h00);
    chk("remote bit", 8'h7d, resp_last[7:0]);
    // Trim lock, receiver option and calibration sync
    cmd(1'b1, ADDR_CTRL, 8'h40);
    chk("unlock", 8'h00, {7'h00, trim_unl});
    cmd(1'b1, ADDR_RX_OPT, 8'h99);
    chk("rx option", 8'h00, lp_opt);
    cmd(1'b1, ADDR_CTRL, 8'he0);
    chk("unlock", 8'h01, {7'h00, trim_unl});
    chk("calibration", 8'h01, {7'h00, calib});
    cmd(1'b1, ADDR_RX_OPT, 8'h99);
    chk("rx option", 8'h99, lp_opt);
    txd_level = 1'b0;
    for (k = 0; k < 20 && osc_sync !== 1'b1; k++) step(1);
    chk("sync pulse", 8'h01, {7'h00, osc_sync});
    cmd(1'b1, ADDR_CTRL, 8'h20);
    chk("calibration", 8'h00, {7'h00, calib});
    // Wake frame matching against the programmed identifier
    wake_sel = 1'b1;
    foreach (cases[i]) begin
      cmd(1'b1, ADDR_CTRL, 8'h01);
      chk("valid", 8'h01, {7'h00, cfg_valid});
      rx_ident = {8'ha5, 8'h5a, 8'hc3, 5'h1f} ^ cases[i].flip;
      rx_ide = cases[i].ide;
      rx_rtr = cases[i].rtr;
      rx_len = cases[i].len;
      rx_valid = 1'b1;
      step(1);
      rx_valid = 1'b0;
      chk("wake", {7'h00, cases[i].hit}, {7'h00, wake_det});
      step(1);
      chk("valid", {7'h00, ~cases[i].hit}, {7'h00, cfg_valid});
    end
    // Standard identifier ignores bits 17 to 0; no wake once invalid
    cmd(1'b1, ADDR_ID0, 8'h7c);
    cmd(1'b1, ADDR_CTRL, 8'h01);
    rx_ident = {8'ha5, 8'h5a, 8'hc3, 5'h1e};
    rx_ide = 1'b0;
    rx_len = 4'hf;
    rx_valid = 1'b1;
    step(1);
    rx_valid = 1'b0;
    chk("std wake", 8'h01, {7'h00, wake_det});
    step(1);
    rx_valid = 1'b1;
    step(1);
    rx_valid = 1'b0;
    chk("wake", 8'h00, {7'h00, wake_det});
    // Automatic clearing of the valid bit
    cmd(1'b1, ADDR_CTRL, 8'h01);
    cmd(1'b1, ADDR_QUANTA, 8'h7e);
    chk("valid", 8'h00, {7'h00, cfg_valid});
    cmd(1'b1, ADDR_CTRL, 8'h01);
    stop_mode = 1'b1;
    cmd(1'b1, ADDR_QUANTA, 8'h7e);
    chk("valid", 8'h00, {7'h00, cfg_valid});
    cmd(1'b1, ADDR_CTRL, 8'h01);
    chk("valid", 8'h00, {7'h00, cfg_valid});
    stop_mode = 1'b0;
    cmd(1'b1, ADDR_CTRL, 8'h01);
    wake_evt = 1'b1;
    step(1);
    wake_evt = 1'b0;
    step(1);
    chk("valid", 8'h00, {7'h00, cfg_valid});
    // Time-out flag and its interrupt
    wake_sel = 1'b0;
    to_evt = 1'b1;
    step(1);
    to_evt = 1'b0;
    step(2);
    chk("timeout", 8'h00, {7'h00, to_flag});
    wake_sel = 1'b1;
    to_evt = 1'b1;
    step(1);
    to_evt = 1'b0;
    step(2);
    chk("timeout", 8'h01, {7'h00, to_flag});
    chk("irq", 8'h00, {7'h00, irq});
    cmd(1'b1, ADDR_CTRL, 8'h10);
    chk("irq", 8'h01, {7'h00, irq});
    cmd(1'b0, ADDR_CTRL, 8'h00);
    step(2);
    chk("irq", 8'h00, {7'h00, irq});
    // Soft reset restores defaults
    soft_rst = 1'b1;
    step(1);
    soft_rst = 1'b0;
    step(1);
    chk("quanta", 8'ha0, quanta);
    chk("sample", 8'h33, {2'b00, sample});
    cmd(1'b0, ADDR_ID3, 8'h00);
    cmd(1'b0, 7'h7f, 8'h00);
    chk("ident", 8'h00, resp_last[7:0]);
    complete_run();
  end
endmodule
